// ### rtl/prs_pkg.sv
package prs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MEM_DELAY_MS  = 2;
  localparam int unsigned MEM_DELAY_CYC = MEM_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W         = 18;

  // ----------------------------------------------------------------
  // strap and selection codes
  // ----------------------------------------------------------------
  localparam logic       CFG_FIRST    = 1'b0;
  localparam logic       CFG_SECOND   = 1'b1;
  localparam logic [1:0] MEM_SEL_1V2  = 2'h0;
  localparam logic [1:0] MEM_SEL_1V35 = 2'h1;
  localparam logic       BRAM_SEL_085 = 1'b0;
  localparam logic       BRAM_SEL_090 = 1'b1;
  localparam logic [1:0] SWB_TGT_NONE = 2'h0;
  localparam logic [1:0] SWB_TGT_B2   = 2'h1;
  localparam logic       SHARED_TGT_LIN_ONE = 1'b1;
  localparam logic       SLEEP_SEL_RST      = 1'b1;
  localparam int unsigned SYNC_W      = 10;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic control_pin_six;
    logic control_pin_five;
    logic control_pin_four;
    logic control_pin_three;
    logic control_pin_two;
    logic control_pin_one;
  } prs_ctl_s;

  typedef struct packed {
    logic block_ram;
    logic rail_five;
    logic memory;
  } prs_pg_s;

  typedef struct packed {
    logic general_linear_two;
    logic general_linear_three;
    logic load_switch_a;
    logic load_switch_b1;
    logic load_switch_b2;
  } prs_cmd_s;

  typedef struct packed {
    logic block_ram_rail_controller;
    logic converter_rail_three;
    logic converter_rail_five;
    logic memory_rail_controller;
    logic general_linear_one;
    logic general_linear_two;
    logic general_linear_three;
    logic termination_regulator;
    logic load_switch_a;
    logic load_switch_b1;
    logic load_switch_b2;
  } prs_rail_s;

  localparam prs_rail_s RAILS_OFF = '0;

endpackage

// ### rtl/prs_delay_timer.sv
`timescale 1ns/1ps
module prs_delay_timer
  import prs_pkg::*;
#(
  parameter int unsigned CYCLES = MEM_DELAY_CYC
)
(
  input  wire logic sys_clk_in, // system clock
  input  wire logic reset_n_in, // async reset, active low
  input  wire logic run_in,     // count while high, clear when low
  output logic      done_out    // high once CYCLES have passed
);

  localparam logic [TMR_W-1:0] LAST = TMR_W'(CYCLES - 1);

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic             done_nxt;

  // ----------------------------------------------------------------
  // count, saturate at the end
  // ----------------------------------------------------------------
  assign cnt_nxt  = !run_in ? '0 : (done_out ? cnt_r : cnt_r + 1'b1);
  assign done_nxt = run_in && (done_out || cnt_r == LAST);

  // restarting on any drop keeps a glitching rail from skipping the wait
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_r    <= '0;
      done_out <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      done_out <= done_nxt;
    end
  end

endmodule

// ### rtl/prs_rail_sequencer.sv
`timescale 1ns/1ps
module prs_rail_sequencer
  import prs_pkg::*;
#(
  parameter int unsigned MEM_DELAY = MEM_DELAY_CYC
)
(
  input  wire logic      sys_clk_in,      // 100 MHz clock
  input  wire logic      reset_n_in,      // async reset, active low
  input  wire logic      cfg_second_in,   // strap: 0 first config, 1 second
  input  wire prs_ctl_s  ctl_pins_in,     // control pins, asynchronous
  input  wire prs_pg_s   pg_in,           // regulator power-good, asynchronous
  input  wire prs_cmd_s  cmd_in,          // serial command enables, same clock
  output prs_rail_s      rail_en_out,     // regulator and switch enables
  output prs_rail_s      discharge_out,   // discharge resistor connected
  output logic           gen_out_one_out, // general output one
  output logic [1:0]     mem_vsel_out,    // memory rail voltage code
  output logic           bram_vsel_out,   // block-RAM rail voltage code
  output logic           sleep_sel_out,   // rail three sleep select
  output logic           sleep_code_out,  // rail three sleep code field is live
  output logic           shared_tgt_out,  // shared registers act on linear one
  output logic [1:0]     swb_tgt_out,     // switch-B register target
  output logic           swb_merged_out   // B1 and B2 run as one switch
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;

  assign raw = {cfg_second_in, pg_in, ctl_pins_in};

  // two flops per bit; only the second flop is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= raw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  prs_ctl_s ctl;
  prs_pg_s  pg;
  logic     cfg_s;
  wire logic c1 = ctl.control_pin_one;
  wire logic c2 = ctl.control_pin_two;
  wire logic c3 = ctl.control_pin_three;
  wire logic c4 = ctl.control_pin_four;
  wire logic c5 = ctl.control_pin_five;
  wire logic c6 = ctl.control_pin_six;

  assign ctl   = sync_r[5:0];
  assign pg    = sync_r[8:6];
  assign cfg_s = sync_r[9];

  // ----------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------
  prs_rail_s en_r;
  prs_rail_s en_nxt;
  logic      cfg_r;
  logic      gpo_r;
  logic      all_off;

  // the strap is only followed while everything is down, so a bouncing
  // strap can never reshuffle a running sequence
  assign all_off = (en_r == RAILS_OFF) && !gpo_r;

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cfg_r <= CFG_FIRST;
    else if (all_off)
      cfg_r <= cfg_s;
  end

  wire logic cfg2 = (cfg_r == CFG_SECOND);

  // ----------------------------------------------------------------
  // memory rail start delay
  // ----------------------------------------------------------------
  logic tmr_done;

  prs_delay_timer #(
    .CYCLES (MEM_DELAY)
  ) u_mem_delay (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (en_r.converter_rail_five),
    .done_out   (tmr_done)
  );

  // ----------------------------------------------------------------
  // power-up conditions per stage
  // ----------------------------------------------------------------
  logic on_b5, on_gpo, on_bram, on_b3, on_mem, on_la1, on_vtt, on_swa;

  assign on_b5   = cfg2 ? c1 : c3;
  assign on_gpo  = on_b5 && pg.rail_five;
  // first config: output one leaves for the core regulator; its good comes back on pin four
  assign on_bram = cfg2 ? (c1 && c6) : (c3 && c4 && gpo_r);
  assign on_b3   = cfg2 ? (c1 && c4 && pg.block_ram) : (c3 && pg.block_ram);
  assign on_mem  = cfg2 ? (c1 && pg.rail_five)
                        : (c1 && en_r.converter_rail_five && tmr_done);
  assign on_la1  = c1 && pg.memory;
  assign on_vtt  = cfg2 ? (c6 && pg.memory) : (c5 && pg.memory);
  assign on_swa  = cfg2 ? c5 : cmd_in.load_switch_a;

  // ----------------------------------------------------------------
  // next enables with reverse-order release
  // ----------------------------------------------------------------
  // a stage only drops once everything that followed it is already off
  logic dep_b5, dep_gpo, dep_bram, dep_mem, gpo_nxt;

  assign dep_mem  = en_r.general_linear_one || en_r.termination_regulator;
  assign dep_bram = en_r.converter_rail_three;
  assign dep_gpo  = en_r.block_ram_rail_controller;
  assign dep_b5   = gpo_r || en_r.memory_rail_controller;

  assign gpo_nxt = on_gpo || (gpo_r && dep_gpo);

  always_comb
  begin
    en_nxt = RAILS_OFF;
    en_nxt.converter_rail_five       = on_b5 || (en_r.converter_rail_five && dep_b5);
    en_nxt.block_ram_rail_controller = on_bram ||
                                       (en_r.block_ram_rail_controller && dep_bram);
    en_nxt.converter_rail_three      = on_b3;
    en_nxt.memory_rail_controller    = on_mem ||
                                       (en_r.memory_rail_controller && dep_mem);
    en_nxt.general_linear_one        = on_la1;
    en_nxt.termination_regulator     = on_vtt;
    en_nxt.general_linear_two        = cmd_in.general_linear_two;
    en_nxt.general_linear_three      = cmd_in.general_linear_three;
    en_nxt.load_switch_a             = on_swa;
    en_nxt.load_switch_b1            = cmd_in.load_switch_b1;
    // merged pair follows the B1 command; the B2 command is ignored
    en_nxt.load_switch_b2            = cfg2 ? cmd_in.load_switch_b1
                                            : cmd_in.load_switch_b2;
  end

  // ----------------------------------------------------------------
  // selections and register targets
  // ----------------------------------------------------------------
  logic [1:0] mem_vsel_nxt;
  logic       bram_vsel_nxt;
  logic       sleep_code_nxt;
  logic [1:0] swb_tgt_nxt;

  assign mem_vsel_nxt   = cfg2 ? {c2, c3}
                               : (c2 ? MEM_SEL_1V35 : MEM_SEL_1V2);
  assign bram_vsel_nxt  = (!cfg2 && c6) ? BRAM_SEL_090 : BRAM_SEL_085;
  assign sleep_code_nxt = !cfg2 && !c6;
  assign swb_tgt_nxt    = cfg2 ? SWB_TGT_NONE : SWB_TGT_B2;

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // discharge follows the enable with no software step
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      en_r          <= RAILS_OFF;
      gpo_r         <= 1'b0;
      discharge_out <= ~RAILS_OFF;
    end
    else
    begin
      en_r          <= en_nxt;
      gpo_r         <= gpo_nxt;
      discharge_out <= ~en_nxt;
    end
  end

  // selections and targets
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mem_vsel_out   <= MEM_SEL_1V2;
      bram_vsel_out  <= BRAM_SEL_085;
      sleep_sel_out  <= SLEEP_SEL_RST;
      sleep_code_out <= 1'b0;
      shared_tgt_out <= SHARED_TGT_LIN_ONE;
      swb_tgt_out    <= SWB_TGT_B2;
      swb_merged_out <= 1'b0;
    end
    else
    begin
      mem_vsel_out   <= mem_vsel_nxt;
      bram_vsel_out  <= bram_vsel_nxt;
      sleep_sel_out  <= SLEEP_SEL_RST;
      sleep_code_out <= sleep_code_nxt;
      shared_tgt_out <= SHARED_TGT_LIN_ONE;
      swb_tgt_out    <= swb_tgt_nxt;
      swb_merged_out <= cfg2;
    end
  end

  assign rail_en_out     = en_r;
  assign gen_out_one_out = gpo_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_gpo_needs_pg;
    $rose(gpo_r) |-> $past(pg.rail_five && on_b5);
  endproperty
  a_gpo_needs_pg: assert property (p_gpo_needs_pg)
    else $error("output one rose without rail five good");

  property p_mem_gate_first;
    (!cfg2 && $rose(en_r.memory_rail_controller)) |-> $past(c1);
  endproperty
  a_mem_gate_first: assert property (p_mem_gate_first)
    else $error("memory rail rose without pin one");

  property p_mem_delay;
    (!cfg2 && $rose(en_r.converter_rail_five)) |-> !en_r.memory_rail_controller [*8];
  endproperty
  a_mem_delay: assert property (p_mem_delay)
    else $error("memory rail started before the delay");

  property p_la1_after_pg;
    $rose(en_r.general_linear_one) |-> $past(pg.memory);
  endproperty
  a_la1_after_pg: assert property (p_la1_after_pg)
    else $error("linear one rose before memory good");

  property p_vtt_after_pg;
    (!cfg2 && $rose(en_r.termination_regulator)) |-> $past(pg.memory && c5);
  endproperty
  a_vtt_after_pg: assert property (p_vtt_after_pg)
    else $error("termination rose without memory good and pin five");

  property p_mem_vsel_first;
    !cfg2 |=> mem_vsel_out == ($past(c2) ? MEM_SEL_1V35 : MEM_SEL_1V2);
  endproperty
  a_mem_vsel_first: assert property (p_mem_vsel_first)
    else $error("memory voltage code wrong");

  property p_bram_vsel;
    !cfg2 |=> bram_vsel_out == $past(c6);
  endproperty
  a_bram_vsel: assert property (p_bram_vsel)
    else $error("block-RAM voltage code wrong");

  property p_sleep_code;
    !cfg2 |=> (sleep_sel_out && sleep_code_out == !$past(c6));
  endproperty
  a_sleep_code: assert property (p_sleep_code)
    else $error("rail three code field selection wrong");

  property p_serial_only;
    1'b1 |=> en_r.general_linear_two == $past(cmd_in.general_linear_two) &&
             en_r.general_linear_three == $past(cmd_in.general_linear_three);
  endproperty
  a_serial_only: assert property (p_serial_only)
    else $error("linear two or three not following command");

  property p_targets_first;
    !cfg2 |=> (swb_tgt_out == SWB_TGT_B2) && shared_tgt_out && !swb_merged_out;
  endproperty
  a_targets_first: assert property (p_targets_first)
    else $error("register targets wrong in first config");

  property p_merged;
    cfg2 |=> (en_r.load_switch_b1 == en_r.load_switch_b2) && (swb_tgt_out == SWB_TGT_NONE);
  endproperty
  a_merged: assert property (p_merged)
    else $error("switches not merged in second config");

  property p_start_pin_one;
    (cfg2 && $rose(en_r.converter_rail_five)) |-> $past(c1);
  endproperty
  a_start_pin_one: assert property (p_start_pin_one)
    else $error("second config started without pin one");

  property p_swa_pin;
    cfg2 |=> en_r.load_switch_a == $past(c5);
  endproperty
  a_swa_pin: assert property (p_swa_pin)
    else $error("load switch A not following pin five");

  property p_mem_vsel_second;
    cfg2 |=> mem_vsel_out == $past({c2, c3});
  endproperty
  a_mem_vsel_second: assert property (p_mem_vsel_second)
    else $error("memory voltage code wrong in second config");

  property p_discharge;
    $rose(en_r.memory_rail_controller) |-> !discharge_out.memory_rail_controller
      ##1 (discharge_out.memory_rail_controller == !en_r.memory_rail_controller);
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("discharge still connected on enabled rail");

  property p_reverse_off;
    $fell(en_r.converter_rail_five) |-> $past(!gpo_r && !en_r.memory_rail_controller);
  endproperty
  a_reverse_off: assert property (p_reverse_off)
    else $error("rail five dropped before its followers");

endmodule

// ### sim/prs_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host pins, regulator power-good and optional external core rail
// ----------------------------------------------------------------
module prs_host_model
  import prs_pkg::*;
(
  input  wire logic       sys_clk_in,  // system clock
  input  wire prs_ctl_s   host_in,     // levels the host drives
  input  wire prs_rail_s  rail_en_in,  // enables from the sequencer
  input  wire logic       gen_one_in,  // general output one
  input  wire logic       use_ext_in,  // external core regulator fitted
  input  wire logic       tie_six_in,  // pin six strapped to output one
  input  wire logic       ext_fail_in, // external regulator never good
  input  wire logic [3:0] lat_in,      // power-good delay in cycles
  output prs_ctl_s        ctl_out,     // control pins seen by the device
  output prs_pg_s         pg_out       // regulator power-good
);
  logic [15:0] bram_h = '0;
  logic [15:0] five_h = '0;
  logic [15:0] mem_h  = '0;
  logic [15:0] ext_h  = '0;
  logic        ext_pg;
  logic        six_w;
  logic        four_w;

  // enable history; good drops with the enable at once, as a real rail does
  always @(posedge sys_clk_in)
  begin
    bram_h <= #1 {bram_h[14:0], rail_en_in.block_ram_rail_controller};
    five_h <= #1 {five_h[14:0], rail_en_in.converter_rail_five};
    mem_h  <= #1 {mem_h[14:0], rail_en_in.memory_rail_controller};
    ext_h  <= #1 {ext_h[14:0], gen_one_in};
  end

  // external core rail enabled by output one, its good returned on pin four
  assign ext_pg = gen_one_in & ext_h[lat_in] & ~ext_fail_in;
  assign four_w = use_ext_in ? ext_pg : host_in.control_pin_four;
  assign six_w  = tie_six_in ? gen_one_in : host_in.control_pin_six;
  assign ctl_out = {six_w, host_in.control_pin_five, four_w,
                    host_in.control_pin_three, host_in.control_pin_two,
                    host_in.control_pin_one};
  assign pg_out = {rail_en_in.block_ram_rail_controller & bram_h[lat_in],
                   rail_en_in.converter_rail_five & five_h[lat_in],
                   rail_en_in.memory_rail_controller & mem_h[lat_in]};
endmodule

// ### sim/tb_prs_rail_sequencer.sv
`timescale 1ns/1ps
module tb_prs_rail_sequencer
  import prs_pkg::*;
();
  localparam int MD = 16;
  localparam int GEN = 11, BRAM = 10, R3 = 9, R5 = 8, MEM = 7, L1 = 6;
  localparam int L2 = 5, L3 = 4, TERM = 3, SWA = 2, SB1 = 1, SB2 = 0;
  logic       sys_clk_in;
  logic       reset_n_in;
  logic       cfg_second_in;
  logic       use_ext, tie_six, ext_fail;
  logic [3:0] lat;
  prs_ctl_s   host, ctl_pins;
  prs_pg_s    pg;
  prs_cmd_s   cmd_in;
  prs_rail_s  rail_en, disch;
  logic       gen_one, bram_vsel, sleep_sel, sleep_code, shared_tgt, merged;
  logic [1:0] mem_vsel, swb_tgt;
  logic [11:0] obs;
  int         num_errors, checked, n;

  assign obs = {gen_one, rail_en};

  prs_rail_sequencer #(.MEM_DELAY(MD)) dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cfg_second_in(cfg_second_in),
    .ctl_pins_in(ctl_pins), .pg_in(pg), .cmd_in(cmd_in), .rail_en_out(rail_en),
    .discharge_out(disch), .gen_out_one_out(gen_one), .mem_vsel_out(mem_vsel),
    .bram_vsel_out(bram_vsel), .sleep_sel_out(sleep_sel), .sleep_code_out(sleep_code),
    .shared_tgt_out(shared_tgt), .swb_tgt_out(swb_tgt), .swb_merged_out(merged));

  prs_host_model far_side (
    .sys_clk_in(sys_clk_in), .host_in(host), .rail_en_in(rail_en), .gen_one_in(gen_one),
    .use_ext_in(use_ext), .tie_six_in(tie_six), .ext_fail_in(ext_fail), .lat_in(lat),
    .ctl_out(ctl_pins), .pg_out(pg));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // drive and sample 1 ns after the edge so registered outputs have settled
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask

  // bounded wait; n keeps the cycles spent for latency checks
  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v)
    begin
      if (n >= lim)
      begin
        num_errors++;
        $display("Error at %0t: output %0d stuck", $time, b);
        test_done();
      end
      tick(1);
      n++;
    end
  endtask

  task automatic start(input logic cfg);
    reset_n_in = 1'b0;
    cfg_second_in = cfg;
    host = '0;
    cmd_in = '0;
    tick(20);
  endtask

  initial
  begin
    #500_000;
    num_errors++;
    $display("Error at %0t: run hung", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    checked = 0;
    use_ext = 1'b1;
    tie_six = 1'b0;
    ext_fail = 1'b1;
    lat = 4'h4;
    start(1'b0);
    check(rail_en, RAILS_OFF);
    // concatenation keeps the inversion at rail width, not the task's 16 bits
    check(disch, {5'h00, ~RAILS_OFF});
    check({sleep_sel, shared_tgt, swb_tgt}, {SLEEP_SEL_RST, SHARED_TGT_LIN_ONE, SWB_TGT_B2});
    reset_n_in = 1'b1;
    tick(3);
    // first config: external core rail held back by its regulator
    host = 6'h17;
    wait_bit(R5, 1'b1, 10);
    wait_bit(MEM, 1'b1, MD + 4);
    check(n, MD + 1);
    check({obs[L1], obs[TERM]}, 2'h0);
    wait_bit(GEN, 1'b1, 20);
    tick(6);
    check(obs[BRAM], 1'b0);
    ext_fail = 1'b0;
    wait_bit(BRAM, 1'b1, 20);
    wait_bit(R3, 1'b1, 20);
    wait_bit(L1, 1'b1, 20);
    check(obs[TERM], 1'b1);
    check(mem_vsel, MEM_SEL_1V35);
    check(bram_vsel, BRAM_SEL_085);
    check({sleep_sel, sleep_code}, 2'h3);
    check({shared_tgt, swb_tgt, merged}, {SHARED_TGT_LIN_ONE, SWB_TGT_B2, 1'b0});
    check(disch, {5'h00, ~rail_en});
    check({obs[L2], obs[L3]}, 2'h0);
    host = 6'h35;
    tick(4);
    check(mem_vsel, MEM_SEL_1V2);
    check({bram_vsel, sleep_code}, {BRAM_SEL_090, 1'b0});
    cmd_in = 5'h19;
    tick(2);
    check({obs[L2], obs[L3], obs[SB2]}, 3'h7);
    cmd_in = '0;
    // memory part falls back in reverse order
    host = 6'h25;
    wait_bit(TERM, 1'b0, 10);
    check(obs[L1], 1'b1);
    host = 6'h24;
    wait_bit(MEM, 1'b0, 10);
    check({obs[L1], obs[R5]}, 2'h1);
    host = '0;
    wait_bit(R5, 1'b0, 30);
    check({obs[GEN], obs[BRAM], obs[R3]}, 3'h0);
    check(disch, {5'h00, ~rail_en});
    // second config, prompt regulators, pin six tied to output one
    use_ext = 1'b0;
    tie_six = 1'b1;
    lat = 4'h1;
    start(1'b1);
    reset_n_in = 1'b1;
    tick(4);
    check({merged, swb_tgt, shared_tgt}, {1'b1, SWB_TGT_NONE, SHARED_TGT_LIN_ONE});
    host = 6'h10;
    wait_bit(SWA, 1'b1, 10);
    check(obs[R5], 1'b0);
    host = '0;
    cmd_in = 5'h05;
    tick(4);
    check({obs[SWA], obs[SB2]}, 2'h0);
    // merged pair: the B1 command alone must raise both halves
    cmd_in = 5'h02;
    tick(2);
    check({obs[SB1], obs[SB2]}, 2'h3);
    cmd_in = '0;
    host = 6'h09;
    wait_bit(R5, 1'b1, 10);
    wait_bit(GEN, 1'b1, 20);
    wait_bit(BRAM, 1'b1, 20);
    wait_bit(R3, 1'b1, 20);
    wait_bit(L1, 1'b1, 30);
    wait_bit(TERM, 1'b1, 10);
    host = 6'h01;
    wait_bit(R3, 1'b0, 10);
    check(obs[BRAM], 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      host = {3'h0, i[0], i[1], 1'b1};
      tick(4);
      check(mem_vsel, i[1:0]);
    end
    host = '0;
    wait_bit(R5, 1'b0, 40);
    check(rail_en, RAILS_OFF);
    check(disch, {5'h00, ~RAILS_OFF});
    test_done();
  end
endmodule
